// >>> hw/tcc_calc.v
// temperature code capture, register port and correction computation
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defines.vh"
module tcc_calc #(
    parameter CONV_CYCLES = `TCC_CONV_CYCLES // conversion spacing, cycles
) (
    input wire clk,                  // core clock, 100 MHz
    input wire rst_n,                // async reset, active low
    input wire senseEnable,          // sense enable bit
    input wire [7:0] coldCurvature,  // cold curvature coefficient
    input wire [4:0] trimScale,      // trim scale, unsigned
    input wire [5:0] analogTrim,     // analog trim, signed
    input wire [4:0] digitalTrim,    // digital trim, unsigned
    input wire adcValid,             // conversion result strobe
    input wire [9:0] adcCode,        // conversion result
    input wire [7:0] regAddr,        // register address
    input wire [7:0] regWrData,      // register write data
    input wire regWrEn,              // register write strobe
    output reg [7:0] regRdData_r,    // register read data
    output reg convStart_r,          // conversion request pulse
    output reg [9:0] kelvinCode_r,   // averaged temperature code
    output reg kelvinInRange_r,      // code inside practical range
    output reg [19:0] netCorrection_r, // signed net correction
    output reg corrValid_r           // pulse, new net correction
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_SQR = 4'b0010;
    localparam [3:0] ST_SCALE = 4'b0100;
    localparam [3:0] ST_DONE = 4'b1000;
    localparam [16:0] CONV_LAST = CONV_CYCLES - 1;

    reg [4:0] turnoverOffset_r;
    reg [6:0] hotCurvatureField_r;
    reg [16:0] convCnt_r;
    reg halfDone_r;
    reg [9:0] firstCode_r;
    reg pending_r;
    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg coldSel_r;
    reg [19:0] square_r;
    reg multStart_r;
    reg [19:0] opA_r;
    reg [9:0] opB_r;
    wire multDone;
    wire [29:0] multProduct;

    // ==========================================================
    // turnover reference decode
    function [10:0] turnRef;
        input [4:0] field;
        begin
            if (field[`TCC_TURN_SIGN]) begin
                turnRef = `TCC_TURNOVER_BASE - {7'h00, field[3:0]};
            end else begin
                turnRef = `TCC_TURNOVER_BASE + {7'h00, field[3:0]};
            end
        end
    endfunction

    // sign-magnitude: both zero encodings land on the base
    wire [10:0] refCode = turnRef(turnoverOffset_r);
    wire [10:0] codeDiff = {1'b0, kelvinCode_r} - refCode;
    wire [10:0] negDiff = refCode - {1'b0, kelvinCode_r};
    wire [9:0] absDiff = codeDiff[10] ? negDiff[9:0] : codeDiff[9:0];
    wire [7:0] alphaSel = coldSel_r ? coldCurvature
                                    : {1'b0, hotCurvatureField_r};

    // ==========================================================
    // initial correction from trims
    wire signed [11:0] scaledTrim = $signed({1'b0, trimScale}) *
                                    $signed(analogTrim);
    wire signed [11:0] digOffset = $signed({7'h00, digitalTrim}) -
                                   $signed(`TCC_DIG_TRIM_BIAS);
    wire [12:0] initDiff = {scaledTrim[11], scaledTrim} -
                           {digOffset[11], digOffset};
    // doubled so both terms share the twice-correction scale
    wire [13:0] initialCorrection = {initDiff, 1'b0};
    wire [17:0] thermalCorrection =
        multProduct[29:`TCC_SCALE_SHIFT];
    wire [19:0] netSum = {{6{initialCorrection[13]}}, initialCorrection} +
                         {2'b00, thermalCorrection};

    // ==========================================================
    // register port
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // power-up recall of the factory presets
            turnoverOffset_r <= `TCC_TURN_RESET;
            hotCurvatureField_r <= `TCC_HOT_PRESET;
        end else if (regWrEn) begin
            if (regAddr == `TCC_ADDR_TURNOVER) begin
                turnoverOffset_r <= regWrData[4:0];
            end
            if (regAddr == `TCC_ADDR_HOT) begin
                hotCurvatureField_r <= regWrData[6:0];
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData_r <= `TCC_RD_UNMAPPED;
        end else begin
            case (regAddr)
                `TCC_ADDR_TEMP_LO: begin
                    regRdData_r <= kelvinCode_r[7:0];
                end
                `TCC_ADDR_TEMP_HI: begin
                    regRdData_r <= {6'h00, kelvinCode_r[9:8]};
                end
                `TCC_ADDR_TURNOVER: begin
                    regRdData_r <= {3'h0, turnoverOffset_r};
                end
                `TCC_ADDR_HOT: begin
                    regRdData_r <= {1'b0, hotCurvatureField_r};
                end
                default: begin
                    regRdData_r <= `TCC_RD_UNMAPPED;
                end
            endcase
        end
    end

    // ==========================================================
    // conversion pacing, halted while sensing is off
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            convCnt_r <= 17'h0;
            convStart_r <= 1'b0;
        end else if (!senseEnable) begin
            convCnt_r <= 17'h0;
            convStart_r <= 1'b0;
        end else if (convCnt_r == CONV_LAST) begin
            convCnt_r <= 17'h0;
            convStart_r <= 1'b1;
        end else begin
            convCnt_r <= convCnt_r + 17'h1;
            convStart_r <= 1'b0;
        end
    end

    // ==========================================================
    // pairwise averaging of conversion results
    wire [10:0] pairSum = {1'b0, firstCode_r} + {1'b0, adcCode};
    wire codeTaken = adcValid && senseEnable && halfDone_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            halfDone_r <= 1'b0;
            firstCode_r <= `TCC_KELVIN_RESET;
            kelvinCode_r <= `TCC_KELVIN_RESET;
            kelvinInRange_r <= 1'b0;
        end else if (!senseEnable) begin
            halfDone_r <= 1'b0;
        end else if (adcValid) begin
            if (!halfDone_r) begin
                firstCode_r <= adcCode;
                halfDone_r <= 1'b1;
            end else begin
                // code is already twice kelvin, passed through unscaled
                kelvinCode_r <= pairSum[10:1];
                kelvinInRange_r <= (pairSum[10:1] >= `TCC_RANGE_LO) &&
                                   (pairSum[10:1] <= `TCC_RANGE_HI);
                halfDone_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // correction sequencer
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (pending_r) begin
                    state_nxt = ST_SQR;
                end
            end
            ST_SQR: begin
                if (multDone) begin
                    state_nxt = ST_SCALE;
                end
            end
            ST_SCALE: begin
                if (multDone) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            pending_r <= 1'b0;
            coldSel_r <= 1'b0;
            square_r <= 20'h0;
            multStart_r <= 1'b0;
            opA_r <= 20'h0;
            opB_r <= 10'h0;
            netCorrection_r <= 20'h0;
            corrValid_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            multStart_r <= 1'b0;
            corrValid_r <= 1'b0;
            if ((state_r == ST_IDLE) && pending_r) begin
                pending_r <= 1'b0;
                coldSel_r <= codeDiff[10];
                opA_r <= {10'h000, absDiff};
                opB_r <= absDiff;
                multStart_r <= 1'b1;
            end
            // a result arriving on the clear cycle is kept
            if (codeTaken) begin
                pending_r <= 1'b1;
            end
            if ((state_r == ST_SQR) && multDone) begin
                square_r <= multProduct[19:0];
                opA_r <= multProduct[19:0];
                opB_r <= {2'b00, alphaSel};
                multStart_r <= 1'b1;
            end
            if ((state_r == ST_SCALE) && multDone) begin
                netCorrection_r <= netSum;
                corrValid_r <= 1'b1;
            end
        end
    end

    tcc_mult u_mult (
        .clk(clk),
        .rst_n(rst_n),
        .start(multStart_r),
        .opA(opA_r),
        .opB(opB_r),
        .done_r(multDone),
        .product_r(multProduct)
    );
endmodule
`default_nettype wire

// >>> common/tcc_defines.vh
// constants for the temperature compensation calculator
// What this block does
// - temperature shown as 10-bit code, low byte bits 7:0, high byte bits 9:8
// - reported code is the average of two successive conversions
// - code is twice the absolute temperature; Celsius is code halved minus 273
// - conversions run only while the sense enable bit is one
// - practical code range is 446 to 726 decimal
// - net correction is initial correction plus thermal correction, at twice scale
// - thermal correction is curvature times squared code difference, over 4096
// - curvature comes from the cold or hot coefficient by temperature code
// - turnover reference is 596 plus the signed turnover offset field
// - initial correction is a function of the trim and trim scale values
// - turnover offset is 5-bit sign-magnitude at 2Ch, half-degree steps
// - turnover offset defaults to all zeros, meaning 25 degrees
// - presets recalled at power-up, software may overwrite them
// - hot curvature is a 7-bit field at 2Dh, magnitude scaled by 2048
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH

// ==========================================================
// register map
`define TCC_ADDR_TEMP_LO 8'h28
`define TCC_ADDR_TEMP_HI 8'h29
`define TCC_ADDR_TURNOVER 8'h2C
`define TCC_ADDR_HOT 8'h2D
`define TCC_RD_UNMAPPED 8'h00

// ==========================================================
// field layout and reset values
`define TCC_TURN_SIGN 4
`define TCC_TURN_RESET 5'h00
`define TCC_HOT_PRESET 7'h46
`define TCC_KELVIN_RESET 10'h000

// ==========================================================
// arithmetic constants
`define TCC_TURNOVER_BASE 11'h254
`define TCC_CELSIUS_OFFSET 273
`define TCC_RANGE_LO 10'h1BE
`define TCC_RANGE_HI 10'h2D6
`define TCC_DIG_TRIM_BIAS 12'h010
`define TCC_SCALE_SHIFT 12
`define TCC_MULT_LAST 4'h9

// ==========================================================
// timing
`define TCC_CLK_MHZ 100
`define TCC_CONV_PERIOD_US 1000
`define TCC_CONV_CYCLES (`TCC_CONV_PERIOD_US * `TCC_CLK_MHZ)

`endif

// >>> hw/tcc_mult.v
// sequential shift-add multiplier, 20 by 10 bits
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defines.vh"
module tcc_mult (
    input wire clk,            // core clock
    input wire rst_n,          // async reset, active low
    input wire start,          // one-cycle start pulse
    input wire [19:0] opA,     // multiplicand
    input wire [9:0] opB,      // multiplier
    output reg done_r,         // one-cycle pulse, product valid
    output reg [29:0] product_r // unsigned product
);
    reg [29:0] aSh_r;
    reg [9:0] b_r;
    reg [3:0] cnt_r;
    reg run_r;

    // ==========================================================
    // one multiplier bit per cycle, ten cycles per product
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            product_r <= 30'h0;
            aSh_r <= 30'h0;
            b_r <= 10'h0;
            cnt_r <= 4'h0;
            run_r <= 1'b0;
            done_r <= 1'b0;
        end else if (start) begin
            product_r <= 30'h0;
            aSh_r <= {10'h0, opA};
            b_r <= opB;
            cnt_r <= 4'h0;
            run_r <= 1'b1;
            done_r <= 1'b0;
        end else if (run_r) begin
            if (b_r[0]) begin
                product_r <= product_r + aSh_r;
            end
            aSh_r <= {aSh_r[28:0], 1'b0};
            b_r <= {1'b0, b_r[9:1]};
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == `TCC_MULT_LAST) begin
                run_r <= 1'b0;
                done_r <= 1'b1;
            end
        end else begin
            done_r <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> test/tcc_calc_sva.sv
// concurrent checks on the temperature compensation calculator ports
`timescale 1ns/1ps
`default_nettype none
module tcc_calc_sva #(
    parameter CONV_CYCLES = 20 // conversion spacing, cycles
) (
    input wire logic clk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic senseEnable, // sense enable bit
    input wire logic [7:0] regAddr, // register address
    input wire logic [7:0] regWrData, // register write data
    input wire logic regWrEn, // register write strobe
    input wire logic [7:0] regRdData_r, // register read data
    input wire logic convStart_r, // conversion request
    input wire logic [9:0] kelvinCode_r, // averaged code
    input wire logic kelvinInRange_r, // practical range flag
    input wire logic [19:0] netCorrection_r, // net correction
    input wire logic corrValid_r // new correction pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // register port
    chk_rd_unmapped: assert property (
        !(regAddr inside {8'h28, 8'h29, 8'h2C, 8'h2D}) |=> regRdData_r == 0)
        else $error("unmapped read not zero");
    chk_temp_low: assert property (
        regAddr == 8'h28 |=> regRdData_r == $past(kelvinCode_r[7:0]))
        else $error("low temperature byte wrong");
    chk_temp_high: assert property (
        regAddr == 8'h29 |=> regRdData_r == {6'h00, $past(kelvinCode_r[9:8])})
        else $error("high temperature byte wrong");
    chk_turn_readback: assert property (
        regWrEn && regAddr == 8'h2C ##1 regAddr == 8'h2C
        |=> regRdData_r == (8'h1F & $past(regWrData, 2)))
        else $error("turnover readback wrong");
    chk_hot_readback: assert property (
        regWrEn && regAddr == 8'h2D ##1 regAddr == 8'h2D
        |=> regRdData_r == (8'h7F & $past(regWrData, 2)))
        else $error("hot curvature readback wrong");
    // ==========================================================
    // sensing and correction
    chk_range_flag: assert property ($stable(kelvinCode_r) |->
        kelvinInRange_r == (kelvinCode_r >= 10'h1BE && kelvinCode_r <= 10'h2D6))
        else $error("range flag wrong");
    chk_conv_off: assert property (!senseEnable |=> !convStart_r)
        else $error("conversion requested while disabled");
    chk_code_frozen: assert property (
        !senseEnable |=> $stable(kelvinCode_r))
        else $error("code moved while disabled");
    chk_corr_follows: assert property (
        $changed(kelvinCode_r) |-> ##[1:80] corrValid_r)
        else $error("no correction after new code");
    chk_net_held: assert property (
        !corrValid_r |-> $stable(netCorrection_r))
        else $error("net correction moved without pulse");
endmodule
bind tcc_calc tcc_calc_sva #(.CONV_CYCLES(CONV_CYCLES)) u_sva (.clk(clk),
    .rst_n(rst_n), .senseEnable(senseEnable), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdData_r(regRdData_r),
    .convStart_r(convStart_r), .kelvinCode_r(kelvinCode_r),
    .kelvinInRange_r(kelvinInRange_r), .netCorrection_r(netCorrection_r),
    .corrValid_r(corrValid_r));
`default_nettype wire

// >>> test/tcc_calc_bench.sv
// self-checking bench for the temperature compensation calculator
`timescale 1ns/1ps
`default_nettype none
module tcc_calc_bench;
    typedef struct {
        logic [9:0] a, b, code;
        logic [4:0] fld;
        logic [7:0] cold;
        logic inr;
    } tcc_row_t;
    localparam integer TS = 3, AT = -5, DT = 20;
    logic clk, rst_n, senseEnable, adcValid, regWrEn, got;
    logic [7:0] coldCurvature, regAddr, regWrData;
    logic [4:0] trimScale, digitalTrim;
    logic [5:0] analogTrim;
    logic [9:0] adcCode;
    logic [6:0] hotVal;
    wire logic [7:0] regRdData_r;
    wire logic [9:0] kelvinCode_r;
    wire logic [19:0] netCorrection_r;
    wire logic convStart_r, kelvinInRange_r, corrValid_r;
    integer num_errors = 0, compares = 0;
    integer pulses;
    tcc_row_t rows [7];
    // short conversion spacing keeps the run brief
    tcc_calc #(.CONV_CYCLES(20)) uut (.clk(clk), .rst_n(rst_n),
        .senseEnable(senseEnable), .coldCurvature(coldCurvature),
        .trimScale(trimScale), .analogTrim(analogTrim),
        .digitalTrim(digitalTrim), .adcValid(adcValid), .adcCode(adcCode),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
        .regRdData_r(regRdData_r), .convStart_r(convStart_r),
        .kelvinCode_r(kelvinCode_r), .kelvinInRange_r(kelvinInRange_r),
        .netCorrection_r(netCorrection_r), .corrValid_r(corrValid_r));
    always #5 clk = ~clk;
    // ==========================================================
    // helpers
    task automatic check(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic regWrite(input logic [7:0] a, d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1;
        @(negedge clk);
        regWrEn = 0;
    endtask
    task automatic rdCheck(input logic [7:0] a, e);
        regAddr = a;
        @(posedge clk);
        #1;
        check("read data", regRdData_r, e);
        @(negedge clk);
    endtask
    task automatic sendPair(input logic [9:0] a, b);
        adcCode = a;
        adcValid = 1;
        @(negedge clk);
        adcCode = b;
        @(negedge clk);
        adcValid = 0;
    endtask
    task automatic waitCorr();
        integer n;
        n = 0;
        got = 0;
        while (got !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            got = corrValid_r;
            n++;
        end
        @(negedge clk);
    endtask
    task automatic countConv(input integer len, output integer cnt);
        cnt = 0;
        repeat (len) begin
            @(posedge clk);
            #1;
            if (convStart_r === 1'b1) begin
                cnt++;
            end
        end
        @(negedge clk);
    endtask
    function automatic logic [19:0] expNet(input logic [9:0] code,
        input logic [4:0] fld, input logic [7:0] cold);
        integer c, r, al;
        c = code;
        r = fld[4] ? 596 - fld[3:0] : 596 + fld[3:0];
        al = (c < r) ? cold : hotVal;
        return 20'(2 * (TS * AT - (DT - 16)) + ((al * (c - r) * (c - r)) >>> 12));
    endfunction
    task automatic final_report();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        clk = 0;
        rst_n = 0;
        senseEnable = 0;
        adcValid = 0;
        regWrEn = 0;
        regAddr = 0;
        regWrData = 0;
        adcCode = 0;
        coldCurvature = 8'h28;
        trimScale = 5'(TS);
        analogTrim = 6'(AT);
        digitalTrim = 5'(DT);
        hotVal = 7'h46;
        rows[0] = '{10'h258, 10'h259, 10'h258, 5'h00, 8'h28, 1'b1};
        rows[1] = '{10'h1F4, 10'h1F7, 10'h1F5, 5'h10, 8'h5A, 1'b1};
        rows[2] = '{10'h256, 10'h257, 10'h256, 5'h03, 8'h28, 1'b1};
        rows[3] = '{10'h251, 10'h252, 10'h251, 5'h13, 8'h28, 1'b1};
        rows[4] = '{10'h2D6, 10'h2D7, 10'h2D6, 5'h0F, 8'h3C, 1'b1};
        rows[5] = '{10'h1BC, 10'h1BF, 10'h1BD, 5'h1F, 8'hC8, 1'b0};
        rows[6] = '{10'h2D7, 10'h2D8, 10'h2D7, 5'h00, 8'h28, 1'b0};
        repeat (8) @(negedge clk);
        rst_n = 1;
        @(negedge clk);
        rdCheck(8'h2C, 8'h00);
        rdCheck(8'h2D, 8'h46);
        rdCheck(8'h28, 8'h00);
        rdCheck(8'h29, 8'h00);
        rdCheck(8'h30, 8'h00);
        regWrite(8'h2C, 8'hFF);
        rdCheck(8'h2C, 8'h1F);
        // hot value changed only while sensing is off
        regWrite(8'h2D, 8'hD5);
        hotVal = 7'h55;
        rdCheck(8'h2D, 8'h55);
        regWrite(8'h28, 8'hAA);
        rdCheck(8'h28, 8'h00);
        regWrite(8'h2E, 8'h77);
        rdCheck(8'h2E, 8'h00);
        senseEnable = 1;
        foreach (rows[i]) begin
            regWrite(8'h2C, {3'b000, rows[i].fld});
            coldCurvature = rows[i].cold;
            sendPair(rows[i].a, rows[i].b);
            waitCorr();
            check("corr valid", got, 1);
            check("kelvin", kelvinCode_r, rows[i].code);
            check("in range", kelvinInRange_r, rows[i].inr);
            check("net", netCorrection_r,
                expNet(rows[i].code, rows[i].fld, rows[i].cold));
            rdCheck(8'h28, rows[i].code[7:0]);
            rdCheck(8'h29, {6'h00, rows[i].code[9:8]});
        end
        senseEnable = 0;
        @(negedge clk);
        sendPair(10'h1F4, 10'h1F4);
        waitCorr();
        check("corr while off", got, 0);
        check("kelvin while off", kelvinCode_r, 10'h2D7);
        // a lone result must be dropped when sensing stops
        senseEnable = 1;
        adcCode = 10'h12C;
        adcValid = 1;
        @(negedge clk);
        adcValid = 0;
        senseEnable = 0;
        @(negedge clk);
        senseEnable = 1;
        sendPair(10'h28A, 10'h28C);
        waitCorr();
        check("kelvin pair", kelvinCode_r, 10'h28B);
        check("net pair", netCorrection_r,
            expNet(10'h28B, 5'h00, 8'h28));
        // conversion requests: none while off, one per 20 cycles while on
        senseEnable = 0;
        countConv(30, pulses);
        check("conv while off", pulses, 0);
        senseEnable = 1;
        countConv(40, pulses);
        check("conv while on", pulses, 2);
        // mid-run reset recalls the presets
        rst_n = 0;
        @(negedge clk);
        check("kelvin in reset", kelvinCode_r, 10'h000);
        check("net in reset", netCorrection_r, 20'h0_0000);
        rst_n = 1;
        @(negedge clk);
        rdCheck(8'h2D, 8'h46);
        rdCheck(8'h2C, 8'h00);
        final_report();
    end
    initial begin
        #200000;
        num_errors++;
        final_report();
    end
endmodule
`default_nettype wire
